// >>> common/cms_pkg.sv
// Package: register map, field layout, gate codes and state types for the sequencer
package cms_pkg;

  // Register byte offsets
  localparam logic [5:0] ADDR_MODE = 6'h00;
  localparam logic [5:0] ADDR_LOAD = 6'h04;
  localparam logic [5:0] ADDR_HOLD = 6'h08;
  localparam logic [5:0] ADDR_CMD = 6'h0c;
  localparam logic [5:0] ADDR_STATUS = 6'h10;
  localparam logic [5:0] ADDR_COUNT = 6'h14;

  // Mode word field positions
  localparam int MODE_GATE_LSB = 12;
  localparam int MODE_GATE_MSB = 15;
  localparam int MODE_SPEC_BIT = 6;
  localparam int MODE_ALT_BIT = 5;
  localparam int MODE_REP_BIT = 4;

  // Command word bits
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_DISARM_BIT = 1;
  localparam int CMD_LOAD_BIT = 2;

  // Status word bits
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_TC_BIT = 1;
  localparam int STAT_TGL_BIT = 2;
  localparam int STAT_SEQ_LSB = 4;
  localparam int STAT_SEQ_MSB = 5;

  // Gate control field codes
  localparam logic [3:0] GATE_NONE = 4'h0;
  localparam logic [3:0] GATE_LEVEL = 4'h1;
  localparam logic [3:0] GATE_EDGE = 4'h2;

  // Count values
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // Sequencer phase, Gray coded along idle, wait, first, second
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_RUN1 = 2'b11,
    SEQ_RUN2 = 2'b10
  } seq_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avm_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avm_rsp_t;

  // Whole state of the sequencer
  typedef struct packed {
    logic [1:0] src_sync;
    logic src_prev;
    logic [1:0] gate_sync;
    logic gate_prev;
    seq_t seq;
    logic [15:0] cnt;
    logic tc;
    logic tgl;
    logic [15:0] mode;
    logic [15:0] load;
    logic [15:0] hold;
    logic ack;
    logic [31:0] rdata;
  } cms_state_t;

  // Every field clears at reset, phase lands on idle
  localparam cms_state_t STATE_RST = '0;

endpackage

// >>> logic/counter_mode_sequencer.sv
// Counter channel mode sequencer with an Avalon-MM register slave
`timescale 1ns/1ps
module counter_mode_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input cms_pkg::avm_req_t avm_req,
  output cms_pkg::avm_rsp_t avm_rsp,
  // Counter pins
  input wire logic src_in,
  input wire logic gate_in,
  output logic tc_out,
  output logic tc_toggle_out
);
  import cms_pkg::*;

  // State register and its next value
  cms_state_t q;
  cms_state_t d;
  // Decoded mode, pin edges and bus strobes
  logic src_rise;
  logic gate_rise;
  logic is_edge;
  logic is_level;
  logic alt;
  logic rep;
  logic qualify;
  logic last_tc;
  logic wr_acc;
  logic rd_take;
  logic [15:0] cmd;

  ////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Register read decode
  function automatic logic [31:0] reg_read(
    input cms_state_t s,
    input logic [5:0] a
  );
    logic [31:0] r;
    r = RD_ZERO;
    unique case (a)
      ADDR_MODE: r[15:0] = s.mode;
      ADDR_LOAD: r[15:0] = s.load;
      ADDR_HOLD: r[15:0] = s.hold;
      ADDR_COUNT: r[15:0] = s.cnt;
      ADDR_STATUS: begin
        r[STAT_ARMED_BIT] = (s.seq != SEQ_IDLE);
        r[STAT_TC_BIT] = s.tc;
        r[STAT_TGL_BIT] = s.tgl;
        r[STAT_SEQ_MSB:STAT_SEQ_LSB] = s.seq;
      end
      default: r = RD_ZERO;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Mode decode and pin edges

  // Mode fields; special gate is stored only
  always_comb begin
    is_edge = (q.mode[MODE_GATE_MSB:MODE_GATE_LSB] == GATE_EDGE);
    is_level = (q.mode[MODE_GATE_MSB:MODE_GATE_LSB] == GATE_LEVEL);
    alt = q.mode[MODE_ALT_BIT];
    rep = q.mode[MODE_REP_BIT];
  end

  // Rising edges seen on second sync stage only
  assign src_rise = q.src_sync[1] & ~q.src_prev;
  assign gate_rise = q.gate_sync[1] & ~q.gate_prev;

  // Source edges that count outside terminal count
  always_comb begin
    unique case (q.seq)
      SEQ_IDLE: qualify = 1'b0;
      SEQ_WAIT: qualify = 1'b0;
      SEQ_RUN1, SEQ_RUN2: qualify = is_level ? q.gate_sync[1] : 1'b1;
    endcase
  end

  // Terminal count that ends the whole sequence
  assign last_tc = !alt || (q.seq == SEQ_RUN2);

  ////////////////////////////////////////////////////////////////
  // Bus strobes

  // Two-cycle access: wait one cycle, then answer
  always_comb begin
    wr_acc = avm_req.write && q.ack;
    rd_take = avm_req.read && !q.ack;
    cmd = merge16(CNT_ZERO, avm_req.writedata, avm_req.byteenable);
  end

  assign avm_rsp.waitrequest = (avm_req.read || avm_req.write) && !q.ack;
  assign avm_rsp.readdata = q.rdata;
  assign tc_out = q.tc;
  assign tc_toggle_out = q.tgl;

  ////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    // Two-stage synchronisers
    d.src_sync = {q.src_sync[0], src_in};
    d.src_prev = q.src_sync[1];
    d.gate_sync = {q.gate_sync[0], gate_in};
    d.gate_prev = q.gate_sync[1];
    // Bus handshake
    d.ack = (avm_req.read || avm_req.write) && !q.ack;
    if (rd_take) begin
      d.rdata = reg_read(q, avm_req.address);
    end
    // Gate edge trigger, armed counters only
    if (q.seq == SEQ_WAIT && (!is_edge || gate_rise)) begin
      d.seq = SEQ_RUN1;
    end
    // Source edge handling
    if (src_rise) begin
      if (q.tc) begin
        // Leaving terminal count counts regardless of gate or arm
        d.tc = 1'b0;
        // Alternate modes reload Hold after the first terminal count
        d.cnt = (alt && q.seq == SEQ_RUN1) ? q.hold : q.load;
        if (q.seq == SEQ_RUN1 && alt) begin
          d.seq = SEQ_RUN2;
        end else if (q.seq != SEQ_IDLE && last_tc) begin
          if (!rep) begin
            d.seq = SEQ_IDLE;
          end else if (is_edge) begin
            d.seq = SEQ_WAIT;
          end else begin
            d.seq = SEQ_RUN1;
          end
        end
      end else if (qualify) begin
        // A count of one or zero enters terminal count on this edge
        if (q.cnt <= CNT_ONE) begin
          d.cnt = CNT_ZERO;
          d.tc = 1'b1;
          d.tgl = ~q.tgl;
        end else begin
          d.cnt = q.cnt - CNT_ONE;
        end
      end
    end
    // Register writes come last so software wins
    if (wr_acc) begin
      unique case (avm_req.address)
        ADDR_MODE: d.mode = merge16(q.mode, avm_req.writedata, avm_req.byteenable);
        ADDR_LOAD: d.load = merge16(q.load, avm_req.writedata, avm_req.byteenable);
        ADDR_HOLD: d.hold = merge16(q.hold, avm_req.writedata, avm_req.byteenable);
        ADDR_CMD: begin
          // Load restarts an alternate pair at its first phase
          if (cmd[CMD_LOAD_BIT]) begin
            d.cnt = q.load;
            d.tc = 1'b0;
            if (d.seq == SEQ_RUN2) begin
              d.seq = SEQ_RUN1;
            end
          end
          // Disarm beats any hardware restart in this cycle
          if (cmd[CMD_DISARM_BIT]) begin
            d.seq = SEQ_IDLE;
          end
          // Arm after a same-cycle disarm re-arms the counter
          if (cmd[CMD_ARM_BIT] && d.seq == SEQ_IDLE) begin
            d.seq = is_edge ? SEQ_WAIT : SEQ_RUN1;
          end
        end
        default: d.mode = d.mode;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Count moves only on a source edge or a register write
  a_source_edges_only: assert property (
    !src_rise && !wr_acc |=> $stable(q.cnt))
    else $error("count moved without source edge");

  // Terminal count always takes the next source edge
  a_tc_always_counts: assert property (
    q.tc && src_rise && !wr_acc |=> !q.tc)
    else $error("terminal count not left on source edge");

  // Self-disarm waits for the edge that leaves terminal count
  a_disarm_after_tc: assert property (
    q.tc && src_rise && !rep && last_tc && q.seq != SEQ_IDLE && !wr_acc
    |=> q.seq == SEQ_IDLE)
    else $error("no self disarm after last terminal count");

  // Single reload always comes from Load
  a_reload_from_load: assert property (
    q.tc && src_rise && !alt && !wr_acc |=> q.cnt == $past(q.load))
    else $error("reload not from load");

  // First alternate reload comes from Hold
  a_reload_from_hold: assert property (
    q.tc && src_rise && alt && q.seq == SEQ_RUN1 && !wr_acc
    |=> q.cnt == $past(q.hold) && q.seq == SEQ_RUN2)
    else $error("first alternate reload not from hold");

  // Repetitive modes never disarm themselves
  a_repeat_stays_armed: assert property (
    rep && q.seq != SEQ_IDLE && !wr_acc |=> q.seq != SEQ_IDLE)
    else $error("repetitive counter disarmed itself");

  // Low gate blocks counting in level mode
  a_level_gate_blocks: assert property (
    is_level && !q.gate_sync[1] && !q.tc && src_rise && !wr_acc
    |=> $stable(q.cnt))
    else $error("counted while gate low");

  // Disarmed counter outside terminal count holds its count
  a_disarmed_holds: assert property (
    q.seq == SEQ_IDLE && !q.tc && !wr_acc |=> $stable(q.cnt))
    else $error("disarmed counter counted");

  // Toggle output flips on every entry into terminal count
  a_toggle_on_tc: assert property (
    $rose(q.tc) |-> q.tgl != $past(q.tgl))
    else $error("toggle output missed terminal count");

  // Gate edges cannot arm an idle counter
  a_gate_ignored_idle: assert property (
    q.seq == SEQ_IDLE && gate_rise && !wr_acc |=> q.seq == SEQ_IDLE)
    else $error("gate edge armed a disarmed counter");

  // Every bus access sees exactly one wait cycle
  a_bus_answers: assert property (
    avm_rsp.waitrequest |=> !avm_rsp.waitrequest)
    else $error("bus access not answered in two cycles");

  ////////////////////////////////////////////////////////////////
  // Sequence end and restart checks

  // Last terminal count of a repetitive mode restarts without arm
  a_repeat_rearms: assert property (
    q.tc && src_rise && rep && last_tc && q.seq != SEQ_IDLE && !wr_acc
    |=> q.seq == (is_edge ? SEQ_WAIT : SEQ_RUN1))
    else $error("repetitive counter did not restart");

  // Single reload without repetition ends on the first terminal count
  a_single_ends_once: assert property (
    q.tc && src_rise && !alt && !rep && q.seq != SEQ_IDLE && !wr_acc
    |=> q.seq == SEQ_IDLE)
    else $error("single sequence did not end on first terminal count");

  // Second alternate terminal count reloads Load and closes the pair
  a_alt_second_ends: assert property (
    q.tc && src_rise && alt && q.seq == SEQ_RUN2 && !wr_acc
    |=> q.cnt == $past(q.load) && q.seq != SEQ_RUN2)
    else $error("second alternate reload not from load");

  ////////////////////////////////////////////////////////////////
  // Gate checks

  // Armed edge-gated counter starts on a rising gate edge
  a_gate_edge_starts: assert property (
    q.seq == SEQ_WAIT && is_edge && !q.tc && gate_rise && !wr_acc |=> q.seq == SEQ_RUN1)
    else $error("gate edge did not start an armed counter");

  // Without a rising gate edge the counter keeps waiting
  a_no_falling_trigger: assert property (
    q.seq == SEQ_WAIT && is_edge && !q.tc && !gate_rise && !wr_acc |=> q.seq == SEQ_WAIT)
    else $error("counter left wait without rising gate edge");

  // Waiting for the gate edge outside terminal count holds the count
  a_wait_holds_count: assert property (
    q.seq == SEQ_WAIT && !q.tc && !wr_acc |=> $stable(q.cnt))
    else $error("counted before gate edge");

  // Ungated running counter takes every source edge
  a_no_gate_counts: assert property (
    !is_level && q.seq inside {SEQ_RUN1, SEQ_RUN2} && !q.tc
    && src_rise && q.cnt > CNT_ONE && !wr_acc |=> q.cnt == $past(q.cnt) - CNT_ONE)
    else $error("ungated counter missed a source edge");

  // Level-gated counter counts while the gate is high
  a_level_gate_counts: assert property (
    is_level && q.gate_sync[1] && q.seq inside {SEQ_RUN1, SEQ_RUN2} && !q.tc
    && src_rise && q.cnt > CNT_ONE && !wr_acc |=> q.cnt == $past(q.cnt) - CNT_ONE)
    else $error("gated counter missed a source edge with gate high");

  ////////////////////////////////////////////////////////////////
  // Command and output checks

  // Arm command starts an idle counter
  a_arm_starts: assert property (
    wr_acc && avm_req.address == ADDR_CMD && cmd[CMD_ARM_BIT] && q.seq == SEQ_IDLE
    |=> q.seq != SEQ_IDLE)
    else $error("arm command did not start the counter");

  // Disarm command alone stops the counter
  a_disarm_stops: assert property (
    wr_acc && avm_req.address == ADDR_CMD && cmd[CMD_DISARM_BIT] && !cmd[CMD_ARM_BIT]
    |=> q.seq == SEQ_IDLE)
    else $error("disarm command did not stop the counter");

  // Terminal count stands until the next source edge
  a_tc_stands: assert property (
    q.tc && !src_rise && !wr_acc |=> q.tc)
    else $error("terminal count dropped without source edge");

  // Load command copies Load into the count and leaves terminal count
  a_load_command: assert property (
    wr_acc && avm_req.address == ADDR_CMD && cmd[CMD_LOAD_BIT]
    |=> q.cnt == $past(q.load) && !q.tc)
    else $error("load command did not reload the count");

  // Main scenarios
  c_reach_tc: cover property ($rose(q.tc));
  c_second_phase: cover property (q.seq == SEQ_RUN2 ##1 q.seq == SEQ_IDLE);
  c_edge_restart: cover property (q.seq == SEQ_WAIT ##1 q.seq == SEQ_RUN1);
  c_repeat_restart: cover property (q.tc && src_rise && rep);
  c_disarm_command: cover property (
    wr_acc && avm_req.address == ADDR_CMD && cmd[CMD_DISARM_BIT]);

endmodule

// >>> bench/pin_model.sv
// Source and gate pin model for the counter channel
`timescale 1ns/1ps
module pin_model (
  // Clock
  input wire logic sys_clk,
  // Counter pins
  output logic src_in,
  output logic gate_in
);
  initial begin
    src_in = 1'b0;
    gate_in = 1'b0;
  end
  // Source pulses, high held w cycles and low w+1 cycles, then sync settles
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      @(posedge sys_clk) src_in <= 1'b1;
      repeat (w) @(posedge sys_clk);
      src_in <= 1'b0;
      repeat (w) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask
  // Gate level change, then sync settles
  task automatic gate(input logic v);
    @(posedge sys_clk) gate_in <= v;
    repeat (5) @(posedge sys_clk);
  endtask
endmodule

// >>> bench/counter_mode_sequencer_tb.sv
// Self-checking bench for the counter mode sequencer
`timescale 1ns/1ps
module counter_mode_sequencer_tb;
  import cms_pkg::*;
  typedef struct packed {
    logic [15:0] mode;
    logic [7:0] n;
    logic gate;
    logic [15:0] cnt;
    logic [7:0] st;
  } row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  avm_req_t req = '0;
  avm_rsp_t rsp;
  logic src_in;
  logic gate_in;
  logic tc_out;
  logic tc_toggle_out;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] rd;
  // Mode, pulses, gate level, expected count and status
  localparam row_t ROWS [9] = '{
    '{16'h0000, 8'h03, 1'b0, 16'h0000, 8'h37},
    '{16'h0000, 8'h06, 1'b1, 16'h0003, 8'h04},
    '{16'h0010, 8'h06, 1'b0, 16'h0001, 8'h35},
    '{16'h0020, 8'h05, 1'b0, 16'h0001, 8'h25},
    '{16'h0020, 8'h08, 1'b0, 16'h0003, 8'h00},
    '{16'h0030, 8'h08, 1'b0, 16'h0002, 8'h31},
    '{16'h1000, 8'h03, 1'b0, 16'h0003, 8'h31},
    '{16'h1000, 8'h03, 1'b1, 16'h0000, 8'h37},
    '{16'h2000, 8'h03, 1'b1, 16'h0003, 8'h11}
  };
  always #50 sys_clk = ~sys_clk;
  counter_mode_sequencer u_dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .avm_req(req),
    .avm_rsp(rsp),
    .src_in(src_in),
    .gate_in(gate_in),
    .tc_out(tc_out),
    .tc_toggle_out(tc_toggle_out)
  );
  pin_model u_pins (
    .sys_clk(sys_clk),
    .src_in(src_in),
    .gate_in(gate_in)
  );
  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_of_test();
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // One Avalon cycle, held until waitrequest is low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    req.read <= ~w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'h3;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (rsp.waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      end_of_test();
    end
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  // Read and compare a register
  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  // Reset pulse
  task automatic do_reset();
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
  endtask
  // Mode, Load 3, Hold 2, load count, disarm, then arm
  task automatic setup(input logic [15:0] m);
    bus(1'b1, ADDR_MODE, {16'h0000, m});
    bus(1'b1, ADDR_LOAD, 32'h0000_0003);
    bus(1'b1, ADDR_HOLD, 32'h0000_0002);
    bus(1'b1, ADDR_CMD, 32'h0000_0004);
    bus(1'b1, ADDR_CMD, 32'h0000_0002);
    bus(1'b1, ADDR_CMD, 32'h0000_0001);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Table of ordinary modes
    foreach (ROWS[i]) begin
      do_reset();
      u_pins.gate(ROWS[i].gate);
      setup(ROWS[i].mode);
      u_pins.pulses(int'(ROWS[i].n), 2);
      rchk("count", ADDR_COUNT, {16'h0000, ROWS[i].cnt});
      rchk("status", ADDR_STATUS, {24'h0, ROWS[i].st});
      chk("tc_out", {31'h0, ROWS[i].st[1]}, {31'h0, tc_out});
      chk("toggle", {31'h0, ROWS[i].st[2]}, {31'h0, tc_toggle_out});
    end
    // Edge repetitive mode with gate edges both ways
    do_reset();
    u_pins.gate(1'b0);
    setup(16'h2010);
    rchk("status", ADDR_STATUS, 32'h0000_0011);
    u_pins.gate(1'b1);
    rchk("status", ADDR_STATUS, 32'h0000_0031);
    u_pins.gate(1'b0);
    u_pins.pulses(3, 3);
    chk("tc_out", 32'h0000_0001, {31'h0, tc_out});
    rchk("status", ADDR_STATUS, 32'h0000_0037);
    u_pins.pulses(1, 2);
    rchk("status", ADDR_STATUS, 32'h0000_0015);
    u_pins.pulses(2, 2);
    rchk("count", ADDR_COUNT, 32'h0000_0003);
    u_pins.gate(1'b1);
    rchk("status", ADDR_STATUS, 32'h0000_0035);
    // Another reset in mid-run
    do_reset();
    chk("tc_toggle_out", 32'h0, {31'h0, tc_toggle_out});
    rchk("status", ADDR_STATUS, 32'h0);
    // Disarm command stops a continuous count
    setup(16'h0010);
    u_pins.pulses(1, 2);
    bus(1'b1, ADDR_CMD, 32'h0000_0002);
    u_pins.pulses(2, 2);
    rchk("count", ADDR_COUNT, 32'h0000_0002);
    rchk("status", ADDR_STATUS, 32'h0);
    // Mode readback, write-only and unmapped places
    bus(1'b1, ADDR_MODE, 32'h0000_2070);
    rchk("mode", ADDR_MODE, 32'h0000_2070);
    rchk("cmd", ADDR_CMD, 32'h0);
    bus(1'b1, 6'h3c, 32'h0000_ffff);
    rchk("unmapped", 6'h3c, 32'h0);
    end_of_test();
  end
endmodule
